// *** logic/buck_startup_hiccup_sequencer.sv ***
// Summary of operation
// - both drivers off while supply or enable comparator is low
// - switching resumes only when supply and enable are both high
// - power-on-ready when supply and enable are both high; it starts soft-start
// - turn on only after enable comparator reports above threshold
// - enable low puts both drivers in high impedance
// - low-side stays off until first high-side pulse
// - low-side width steps 25, 50, 75, 100 percent of steady width
// - 32, 16, then 8 pulses at each low-side step level
// - soft-start reference rises linearly from zero to full value
// - over-current protection active during the soft-start ramp
// - over-current when sense node below ground while low-side on
// - over-current comparator ignored for blanking after low-side on
// - trip sets latched over-current flag and enters hiccup
// - hiccup holds reference at zero for set switching cycles
// - hiccup end clears flag and reruns soft-start, repeating
`include "buck_seq_defs.svh"

module buck_startup_hiccup_sequencer
   import buck_seq_pkg::*;
#(
   parameter int HICCUP_CYCLES = `HICCUP_CYCLES
) (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // analog comparator results
   input  wire logic                 supplyAbove,
   input  wire logic                 enableAbove,
   input  wire logic                 ocBelowGnd,
   input  wire logic                 pwmDemand,
   input  wire logic                 oscPulse,
   // gate drivers
   output logic                      highSideGate,
   output logic                      highSideOe,
   output logic                      lowSideGate,
   output logic                      lowSideOe,
   // status and reference
   output logic                      porReady,
   output logic                      overcurrentFlag,
   output logic                      hiccupActive,
   output logic [`SS_REF_W-1:0]      ssRef,
   output logic                      ssDone
);

   seqRegs_t   s_r;
   seqRegs_t   s_nxt;
   ss_ramp_if  rampBus ();

   ss_ramp_gen uRamp (
      .clk_sys (clk_sys),
      .rst     (rst),
      .rp      (rampBus)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [`PB_CNT_W-1:0] pbTarget(input logic [1:0] st);
      case (st)
         2'h0:    pbTarget = `PB_CNT_W'(`PB_CNT_Q1);
         2'h1:    pbTarget = `PB_CNT_W'(`PB_CNT_Q2);
         default: pbTarget = `PB_CNT_W'(`PB_CNT_Q3);
      endcase
   endfunction

   // low-side width limit as quarters of the last full off period
   function automatic logic [`PER_W-1:0] pbLimit(
      input logic [`PER_W-1:0] full,
      input logic [1:0]        st
   );
      logic [`PER_W+2:0] prod;
      prod    = {3'h0, full} * ({{`PER_W+1{1'b0}}, st} + (`PER_W+3)'(1));
      pbLimit = prod[`PER_W+1:2];
   endfunction

   logic supOk;
   logic enOk;
   logic ocIn;
   logic pwm;
   logic oscTick;
   logic lsAllowed;

   // only second-stage outputs are read by the logic
   assign supOk   = s_r.sy2[`SY_SUPPLY];
   assign enOk    = s_r.sy2[`SY_ENABLE];
   assign ocIn    = s_r.sy2[`SY_OC];
   assign pwm     = s_r.sy2[`SY_PWM];
   assign oscTick = s_r.sy2[`SY_OSC] & ~s_r.oscD;

   always_comb begin
      lsAllowed = 1'b0;
      if (s_r.hsSeen) begin
         if (s_r.pbStep == `PB_STEP_FULL) begin
            lsAllowed = 1'b1;
         end else begin
            lsAllowed = s_r.lsOn < pbLimit(s_r.lastOff, s_r.pbStep);
         end
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb begin
      s_nxt      = s_r;
      s_nxt.sy1  = {oscPulse, pwmDemand, ocBelowGnd, enableAbove, supplyAbove};
      s_nxt.sy2  = s_r.sy1;
      s_nxt.pwmD = pwm;
      s_nxt.oscD = s_r.sy2[`SY_OSC];
      s_nxt.por  = supOk & enOk;
      // tri-state only on enable loss; supply loss drives both low
      s_nxt.hsOe   = enOk;
      s_nxt.lsOe   = enOk;
      s_nxt.hsGate = 1'b0;
      s_nxt.lsGate = 1'b0;
      s_nxt.hiccup = 1'b0;

      // period measurement for the steady low-side width
      if (!pwm) begin
         if (s_r.offLen != '1) begin
            s_nxt.offLen = s_r.offLen + `PER_W'(1);
         end
      end else begin
         s_nxt.offLen = '0;
      end
      if (pwm && !s_r.pwmD) begin
         s_nxt.lastOff = s_r.offLen;
      end

      if (!(supOk && enOk)) begin
         // gates stay low and every counter except the off-time measurement restarts
         s_nxt.state  = SEQ_OFF;
         s_nxt.hsSeen = 1'b0;
         s_nxt.pbStep = '0;
         s_nxt.pbCnt  = '0;
         s_nxt.hicCnt = '0;
         s_nxt.lsOn   = '0;
         s_nxt.blank  = '0;
         s_nxt.ocFlag = 1'b0;
      end else begin
         case (s_r.state)
            SEQ_OFF: begin
               // power-on-ready just rose: launch soft-start
               if (s_r.por) begin
                  s_nxt.state = SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               s_nxt.hsGate = pwm;
               if (pwm) begin
                  s_nxt.hsSeen = 1'b1;
               end
               s_nxt.lsGate = ~pwm & lsAllowed;
               if (s_nxt.lsGate) begin
                  s_nxt.lsOn = s_r.lsOn + `PER_W'(1);
                  if (s_r.blank != `BLANK_W'(`OC_BLANK_CYC)) begin
                     s_nxt.blank = s_r.blank + `BLANK_W'(1);
                  end
               end else begin
                  s_nxt.blank = '0;
               end
               // width budget is spent once per off time, renewed when on;
               // clearing it on gate-off would re-fire the low side
               if (pwm) begin
                  s_nxt.lsOn = '0;
               end
               // one pre-bias pulse per switching period
               if (oscTick && s_r.hsSeen && s_r.pbStep != `PB_STEP_FULL) begin
                  if (s_r.pbCnt == pbTarget(s_r.pbStep) - `PB_CNT_W'(1)) begin
                     s_nxt.pbCnt  = '0;
                     s_nxt.pbStep = s_r.pbStep + 2'h1;
                  end else begin
                     s_nxt.pbCnt = s_r.pbCnt + `PB_CNT_W'(1);
                  end
               end
               // comparator looked at only after blanking, ramp or not
               if (s_r.lsGate && ocIn &&
                   s_r.blank == `BLANK_W'(`OC_BLANK_CYC)) begin
                  s_nxt.ocFlag = 1'b1;
                  s_nxt.state  = SEQ_HICCUP;
                  s_nxt.hsGate = 1'b0;
                  s_nxt.lsGate = 1'b0;
                  s_nxt.hicCnt = '0;
               end
            end
            SEQ_HICCUP: begin
               s_nxt.hiccup = 1'b1;
               if (oscTick) begin
                  if (s_r.hicCnt == `HIC_W'(HICCUP_CYCLES - 1)) begin
                     s_nxt.ocFlag = 1'b0;
                     s_nxt.state  = SEQ_RUN;
                     s_nxt.hicCnt = '0;
                     s_nxt.hiccup = 1'b0;
                     s_nxt.hsSeen = 1'b0;
                     s_nxt.pbStep = '0;
                     s_nxt.pbCnt  = '0;
                  end else begin
                     s_nxt.hicCnt = s_r.hicCnt + `HIC_W'(1);
                  end
               end
               s_nxt.lsOn  = '0;
               s_nxt.blank = '0;
            end
            default: begin
               s_nxt.state = SEQ_OFF;
            end
         endcase
      end
   end

   // reference held at zero outside the running state
   assign rampBus.zero = (s_r.state != SEQ_RUN);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign highSideGate    = s_r.hsGate;
   assign highSideOe      = s_r.hsOe;
   assign lowSideGate     = s_r.lsGate;
   assign lowSideOe       = s_r.lsOe;
   assign porReady        = s_r.por;
   assign overcurrentFlag = s_r.ocFlag;
   assign hiccupActive    = s_r.hiccup;
   assign ssRef           = rampBus.lvl;
   assign ssDone          = rampBus.done;

endmodule

// *** logic/buck_seq_defs.svh ***
`ifndef BUCK_SEQ_DEFS_SVH
`define BUCK_SEQ_DEFS_SVH

// clock
`define CLK_PERIOD_NS       5

// soft-start reference: code LSB, full value and slope
`define SS_REF_W            11
`define SS_LSB_UV           1000
`define SS_FULL_MV          2000
`define SS_SLOPE_UV_PER_US  200
`define SS_FULL_CODE        (`SS_FULL_MV * 1000 / `SS_LSB_UV)
`define SS_STEP_NS          (`SS_LSB_UV * 1000 / `SS_SLOPE_UV_PER_US)
`define SS_STEP_CYC         (`SS_STEP_NS / `CLK_PERIOD_NS)
`define SS_PRE_W            12

// over-current blanking after low-side turn-on (least time, rounded up)
`define OC_BLANK_NS         200
`define OC_BLANK_CYC        ((`OC_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_W             6

// hiccup off time in switching cycles
`define HICCUP_CYCLES       4096
`define HIC_W               13

// pre-bias pulse counts per step and step index of full width
`define PB_CNT_Q1           32
`define PB_CNT_Q2           16
`define PB_CNT_Q3           8
`define PB_STEP_FULL        2'h3
`define PB_CNT_W            6

// width of switching period measurements in clock cycles
`define PER_W               12

// synchroniser bit positions
`define SY_SUPPLY           0
`define SY_ENABLE           1
`define SY_OC               2
`define SY_PWM              3
`define SY_OSC              4
`define SY_W                5

`endif

// *** logic/buck_seq_pkg.sv ***
`include "buck_seq_defs.svh"

package buck_seq_pkg;

   typedef enum logic [1:0] {SEQ_OFF, SEQ_RUN, SEQ_HICCUP} seqState_t;

   typedef struct packed {
      logic [`SY_W-1:0]     sy1;
      logic [`SY_W-1:0]     sy2;
      seqState_t            state;
      logic                 pwmD;
      logic                 oscD;
      logic                 hsSeen;
      logic [1:0]           pbStep;
      logic [`PB_CNT_W-1:0] pbCnt;
      logic [`HIC_W-1:0]    hicCnt;
      logic [`PER_W-1:0]    offLen;
      logic [`PER_W-1:0]    lastOff;
      logic [`PER_W-1:0]    lsOn;
      logic [`BLANK_W-1:0]  blank;
      logic                 hsGate;
      logic                 lsGate;
      logic                 hsOe;
      logic                 lsOe;
      logic                 por;
      logic                 ocFlag;
      logic                 hiccup;
   } seqRegs_t;

   typedef struct packed {
      logic [`SS_PRE_W-1:0] pre;
      logic [`SS_REF_W-1:0] lvl;
      logic                 done;
   } rampRegs_t;

endpackage

// *** logic/ss_ramp_if.sv ***
`include "buck_seq_defs.svh"

interface ss_ramp_if;
   logic                 zero;
   logic [`SS_REF_W-1:0] lvl;
   logic                 done;

   modport ctrl (output zero, input lvl, input done);
   modport ramp (input zero, output lvl, output done);
endinterface

// *** logic/ss_ramp_gen.sv ***
`include "buck_seq_defs.svh"

module ss_ramp_gen
   import buck_seq_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // ramp control and value
   ss_ramp_if.ramp   rp
);

   rampRegs_t r_r;
   rampRegs_t r_nxt;

   // ************************************************************
   // soft-start accumulator
   // ************************************************************
   always_comb begin
      r_nxt = r_r;
      if (rp.zero) begin
         r_nxt.pre  = '0;
         r_nxt.lvl  = '0;
         r_nxt.done = 1'b0;
      end else if (r_r.lvl == `SS_REF_W'(`SS_FULL_CODE)) begin
         r_nxt.done = 1'b1;
      end else if (r_r.pre == `SS_PRE_W'(`SS_STEP_CYC - 1)) begin
         // one LSB per step period gives the fixed slope
         r_nxt.pre = '0;
         r_nxt.lvl = r_r.lvl + `SS_REF_W'(1);
      end else begin
         r_nxt.pre = r_r.pre + `SS_PRE_W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign rp.lvl  = r_r.lvl;
   assign rp.done = r_r.done;

endmodule

// *** dv/buck_seq_chk.sv ***
// *****
// start-up and hiccup checks
// *****
module buck_seq_chk #(
   parameter int HICCUP_CYCLES = 4096
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // comparators
   input wire logic        supplyAbove,
   input wire logic        enableAbove,
   input wire logic        ocBelowGnd,
   // drivers and status
   input wire logic        highSideGate,
   input wire logic        highSideOe,
   input wire logic        lowSideGate,
   input wire logic        lowSideOe,
   input wire logic        porReady,
   input wire logic        overcurrentFlag,
   input wire logic        hiccupActive,
   input wire logic [10:0] ssRef
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       hsSeen_r;
   logic [5:0] lsOn_r;
   // run length of the low-side pulse; saturates so long pulses stay legal
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hsSeen_r <= 1'b0;
         lsOn_r   <= 6'h00;
      end else begin
         hsSeen_r <= porReady && !hiccupActive && (hsSeen_r || highSideGate);
         lsOn_r   <= !lowSideGate ? 6'h00 :
                     (lsOn_r == 6'h3F ? lsOn_r : lsOn_r + 6'h01);
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_gate_lockout: assert property ((!supplyAbove || !enableAbove)[*4]
      |-> !highSideGate && !lowSideGate) else $error("gate on in lockout");
   a_hiz_disable: assert property ((!enableAbove)[*4]
      |-> !highSideOe && !lowSideOe) else $error("driver not released");
   a_gate_por: assert property (highSideGate || lowSideGate
      |-> porReady) else $error("gate on before ready");
   a_ls_prebias: assert property (lowSideGate |-> hsSeen_r)
      else $error("low side before first high pulse");
   a_trip_cause: assert property ($rose(overcurrentFlag)
      |-> $past(ocBelowGnd, 3) ##1 hiccupActive) else $error("bad trip");
   a_oc_blanking: assert property ($rose(overcurrentFlag)
      |-> $past(lsOn_r, 3) >= 6'h24) else $error("trip inside blanking");
   a_hic_ref: assert property (hiccupActive[*2] |-> ssRef == 11'h000)
      else $error("reference not held at zero");
   a_ref_step: assert property (porReady && $past(porReady)
      && !hiccupActive && !$past(hiccupActive)
      |-> 11'(ssRef - $past(ssRef)) <= 11'h001) else $error("ramp step");
   a_hic_exit: assert property ($fell(hiccupActive)
      |-> !overcurrentFlag && ssRef == 11'h000) else $error("hiccup exit");
   c_trip: cover property ($rose(overcurrentFlag));
   c_exit: cover property ($fell(hiccupActive));
   c_full: cover property (lowSideGate && lsOn_r > 6'h32);
endmodule

// *** dv/buck_stage_model.sv ***
// *****
// power stage and comparators
// *****
module buck_stage_model (
   // clock and command
   input  wire logic clk_sys,
   input  wire logic ocCmd,
   input  wire logic lowSideGate,
   // comparator outputs
   output logic      oscPulse,
   output logic      pwmDemand,
   output logic      ocBelowGnd
);
   timeunit 1ns;
   timeprecision 100ps;
   int ph = 0;
   initial begin
      oscPulse = 1'b0;
      pwmDemand = 1'b0;
      ocBelowGnd = 1'b0;
   end
   // 200-cycle period, 120-cycle off time
   always @(posedge clk_sys) begin
      ph <= (ph == 199) ? 0 : ph + 1;
      oscPulse <= ph < 10;
      pwmDemand <= ph < 80;
      ocBelowGnd <= ocCmd && lowSideGate;
   end
endmodule

// *** dv/tb_buck_startup_hiccup_sequencer.sv ***
// *****
// start-up sequencer bench
// *****
module tb_buck_startup_hiccup_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys;
   logic        rst = 1'b1;
   logic        supplyAbove = 1'b0;
   logic        enableAbove = 1'b0;
   logic        ocCmd = 1'b0;
   logic        ocBelowGnd, pwmDemand, oscPulse, ssDone;
   logic        highSideGate, highSideOe, lowSideGate, lowSideOe;
   logic        porReady, overcurrentFlag, hiccupActive;
   logic [10:0] ssRef;
   int          error_cnt = 0;
   int          tests_run = 0;
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   buck_startup_hiccup_sequencer #(.HICCUP_CYCLES(4)) dut (.clk_sys, .rst,
      .supplyAbove, .enableAbove, .ocBelowGnd, .pwmDemand, .oscPulse,
      .highSideGate, .highSideOe, .lowSideGate, .lowSideOe, .porReady,
      .overcurrentFlag, .hiccupActive, .ssRef, .ssDone);
   buck_stage_model stage (.clk_sys, .ocCmd, .lowSideGate, .oscPulse,
      .pwmDemand, .ocBelowGnd);
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic drive(input logic s, input logic e, input logic o);
      @(posedge clk_sys);
      supplyAbove <= s;
      enableAbove <= e;
      ocCmd <= o;
   endtask
   // window starts at the off-time edge so one pulse is never split
   task automatic lsWidth(output int w);
      @(negedge pwmDemand);
      w = 0;
      repeat (190) begin
         @(negedge clk_sys);
         if (lowSideGate === 1'b1) w++;
      end
   endtask
   task automatic t_drop;
      drive(1'b1, 1'b0, 1'b0);
      cyc(5);
      chk(!porReady && !highSideOe && !lowSideOe && ssRef === '0, "off");
      drive(1'b0, 1'b1, 1'b0);
      cyc(5);
      chk(highSideOe && !highSideGate && !lowSideGate && !porReady, "uv");
   endtask
   task automatic t_start;
      int w, e;
      drive(1'b1, 1'b1, 1'b0);
      cyc(8);
      chk(porReady === 1'b1, "no ready");
      for (int i = 0; i < 72; i++) begin
         lsWidth(w);
         e = i < 32 ? 30 : i < 48 ? 60 : i < 56 ? 90 : 120;
         if (i == 20 || i == 40 || i == 52 || i == 66)
            chk(w >= e - 3 && w <= e + 3, "low-side width");
         if (i == 18)
            chk(overcurrentFlag === 1'b0, "trip while blanked");
         drive(1'b1, 1'b1, i >= 4 && i < 16);
      end
      cyc(1);
      chk(ssRef >= 11'h00D && ssRef <= 11'h00F, "ramp");
   endtask
   task automatic t_hiccup;
      int k;
      drive(1'b1, 1'b1, 1'b1);
      for (k = 0; k < 400 && overcurrentFlag !== 1'b1; k++) cyc(1);
      chk(overcurrentFlag && !ssDone, "no trip");
      cyc(1);
      chk(hiccupActive === 1'b1, "no hiccup");
      cyc(2);
      chk(ssRef === '0 && lowSideGate === 1'b0, "hiccup ref");
      for (k = 0; k < 2000 && hiccupActive === 1'b1; k++) cyc(1);
      chk(k > 600 && k < 810, "hiccup length");
      chk(overcurrentFlag === 1'b0 && ssRef === '0, "exit");
      for (k = 0; k < 12000 && overcurrentFlag !== 1'b1; k++) cyc(1);
      chk(k > 6000 && k < 12000, "retry trip");
      drive(1'b1, 1'b1, 1'b0);
      cyc(3500);
      chk(!overcurrentFlag && ssRef !== '0, "recovery");
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_drop;
      t_start;
      t_hiccup;
      t_drop;
      end_sim;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      end_sim;
   end
endmodule

bind buck_startup_hiccup_sequencer buck_seq_chk #(
   .HICCUP_CYCLES(HICCUP_CYCLES)) chk (.clk_sys, .rst, .supplyAbove,
   .enableAbove, .ocBelowGnd, .highSideGate, .highSideOe, .lowSideGate,
   .lowSideOe, .porReady, .overcurrentFlag, .hiccupActive, .ssRef);
